// *** inc/flash_program_protect_defines.svh ***
`ifndef FLASH_PROGRAM_PROTECT_DEFINES_SVH
`define FLASH_PROGRAM_PROTECT_DEFINES_SVH

// Array geometry: 8 KB array, 1 KB pages, 2 KB protection blocks, byte addressed 32-bit words
`define FPP_ADDR_W        13
`define FPP_WORD_ADDR_W   11
`define FPP_BLOCKS        4
`define FPP_BLOCK_LSB     11
`define FPP_BLOCK_MSB     12
`define FPP_PAGE_LSB      10
`define FPP_WORD_LSB      2
`define FPP_PAGE_WORDS    256
`define FPP_PAGE_WORD_W   8
`define FPP_ARRAY_WORDS   2048
`define FPP_ERASED_WORD   32'hFFFFFFFF
`define FPP_ZERO_WORD     32'h00000000
// Control word layout
`define FPP_KEY_MSB       31
`define FPP_KEY_LSB       16
`define FPP_KEY_VALUE     16'hA442
`define FPP_WRITE_BIT     0
`define FPP_ERASE_BIT     1
`define FPP_MASS_ERASE_BIT_BIT    2
`define FPP_COMMIT_BIT    3
`define FPP_OP_W          4
// Reset values
`define FPP_PROT_OPEN     4'hF
`define FPP_USEC_RESET    8'h13
`define FPP_USEC_W        8
// Pulse lengths in microseconds
`define FPP_PROGRAM_US    16'h0014
`define FPP_ERASE_US      16'h0028
`define FPP_US_W          16

`endif

// *** inc/flash_program_protect_pkg.sv ***
`default_nettype none
package flash_program_protect_pkg;
  typedef enum logic [2:0] {
    IDLE,
    PROGRAM,
    PAGE_ERASE,
    MASS_ERASE,
    COMMIT
  } seq_state_type;

  typedef logic [3:0] block_bits_type;
endpackage : flash_program_protect_pkg
`default_nettype wire

// *** src/flash_program_protect.sv ***
`include "flash_program_protect_defines.svh"
`default_nettype none
module flash_program_protect (
  input  wire logic                                   MCLK,
  input  wire logic                                   RST_B,
  input  wire logic                                   POWER_ON_RESET,
  input  wire logic [`FPP_USEC_W-1:0]                 MICROSECOND_TICK_RELOAD,
  input  wire logic                                   RELOAD_WRITE,
  input  wire logic [`FPP_ADDR_W-1:0]                 FLASH_TARGET_ADDRESS,
  input  wire logic [31:0]                            FLASH_WRITE_DATA,
  input  wire logic [31:0]                            FLASH_OPERATION_CONTROL,
  input  wire logic                                   CONTROL_WRITE,
  input  wire flash_program_protect_pkg::block_bits_type PROTECT_WRITE_DATA,
  input  wire logic                                   PROGRAM_ENABLE_WRITE,
  input  wire logic                                   READ_ENABLE_WRITE,
  input  wire logic                                   ACCESS_FAULT_MASK,
  input  wire logic                                   FAULT_CLEAR,
  input  wire logic                                   READ_REQUEST,
  input  wire logic                                   READ_IS_FETCH,
  input  wire logic [`FPP_ADDR_W-1:0]                 READ_ADDRESS,
  output logic [31:0]                                 READ_DATA,
  output logic                                        READ_VALID,
  output logic [`FPP_OP_W-1:0]                        OPERATION_BUSY,
  output flash_program_protect_pkg::block_bits_type   BLOCK_PROGRAM_ENABLE_BITS,
  output flash_program_protect_pkg::block_bits_type   BLOCK_READ_ENABLE_BITS,
  output logic [`FPP_USEC_W-1:0]                      RELOAD_VALUE,
  output logic                                        ACCESS_FAULT_RAW,
  output logic                                        ACCESS_FAULT_IRQ
);
  import flash_program_protect_pkg::*;

  typedef struct packed {
    seq_state_type              state;
    logic [`FPP_OP_W-1:0]       op;
    logic [`FPP_ADDR_W-1:0]     addr;
    logic [31:0]                data;
    logic [`FPP_PAGE_WORD_W-1:0] page_idx;
    logic [`FPP_WORD_ADDR_W-1:0] mass_idx;
    logic                       erase_run;
    logic                       commit_pe;
    block_bits_type             pe_live;
    block_bits_type             re_live;
    block_bits_type             pe_saved;
    block_bits_type             re_saved;
    logic [`FPP_USEC_W-1:0]     reload;
    logic                       fault;
    logic [31:0]                rdata;
    logic                       rvalid;
  } ctrl_state_type;

  ctrl_state_type st;
  ctrl_state_type next_st;

  logic [31:0] array_mem [`FPP_ARRAY_WORDS];
  logic        pulse_start;
  logic        pulse_done;
  logic [`FPP_US_W-1:0] pulse_len;
  logic        array_write;
  logic        array_erase_page;
  logic        array_erase_all;

  function automatic logic [1:0] block_of(input logic [`FPP_ADDR_W-1:0] a);
    block_of = a[`FPP_BLOCK_MSB:`FPP_BLOCK_LSB];
  endfunction : block_of

  // Byte lane bits are ignored, so a misaligned address hits the enclosing word
  function automatic logic [`FPP_WORD_ADDR_W-1:0] word_of(input logic [`FPP_ADDR_W-1:0] a);
    word_of = a[`FPP_ADDR_W-1:`FPP_WORD_LSB];
  endfunction : word_of

  flash_pulse_timer u_pulse (
    .MCLK      (MCLK),
    .RST_B     (RST_B),
    .START     (pulse_start),
    .RELOAD    (st.reload),
    .LENGTH_US (pulse_len),
    .DONE      (pulse_done)
  );

  always_comb begin
    logic keyed;
    logic [1:0] blk;
    next_st          = st;
    keyed            = 1'b0;
    blk              = 2'b00;
    pulse_start      = 1'b0;
    pulse_len        = `FPP_PROGRAM_US;
    array_write      = 1'b0;
    array_erase_page = 1'b0;
    array_erase_all  = 1'b0;
    next_st.rvalid   = 1'b0;

    // clear first, so a fault event
    // later in this same cycle still wins
    if (FAULT_CLEAR) begin
      next_st.fault = 1'b0;
    end

    // Software reload change, takes effect at the next tick reload, even during a pulse
    if (RELOAD_WRITE) begin
      next_st.reload = MICROSECOND_TICK_RELOAD;
    end
    if (PROGRAM_ENABLE_WRITE) begin
      next_st.pe_live = st.pe_live & PROTECT_WRITE_DATA;
    end
    if (READ_ENABLE_WRITE) begin
      next_st.re_live = st.re_live & PROTECT_WRITE_DATA;
    end

    if (READ_REQUEST) begin
      next_st.rvalid = 1'b1;
      blk = block_of(READ_ADDRESS);
      if (READ_IS_FETCH || st.re_live[blk]) begin
        next_st.rdata = array_mem[word_of(READ_ADDRESS)];
      end else begin
        next_st.rdata = `FPP_ZERO_WORD;
        next_st.fault = 1'b1;
      end
    end

    case (st.state)
      IDLE: begin
        keyed = CONTROL_WRITE &&
                FLASH_OPERATION_CONTROL[`FPP_KEY_MSB:`FPP_KEY_LSB] == `FPP_KEY_VALUE;
        blk = block_of(FLASH_TARGET_ADDRESS);
        if (keyed) begin
          next_st.addr = FLASH_TARGET_ADDRESS;
          next_st.data = FLASH_WRITE_DATA;
          if (FLASH_OPERATION_CONTROL[`FPP_WRITE_BIT]) begin
            if (st.pe_live[blk]) begin
              next_st.op[`FPP_WRITE_BIT] = 1'b1;
              next_st.state = PROGRAM;
              pulse_start = 1'b1;
            end else begin
              next_st.fault = 1'b1;
            end
          end else if (FLASH_OPERATION_CONTROL[`FPP_ERASE_BIT]) begin
            if (st.pe_live[blk]) begin
              next_st.op[`FPP_ERASE_BIT] = 1'b1;
              next_st.state = PAGE_ERASE;
              pulse_start = 1'b1;
              pulse_len = `FPP_ERASE_US;
            end else begin
              next_st.fault = 1'b1;
            end
          end else if (FLASH_OPERATION_CONTROL[`FPP_MASS_ERASE_BIT_BIT]) begin
            // Mass erase refused when any block is program-protected
            if (&st.pe_live) begin
              next_st.op[`FPP_MASS_ERASE_BIT_BIT] = 1'b1;
              next_st.state = MASS_ERASE;
              pulse_start = 1'b1;
              pulse_len = `FPP_ERASE_US;
            end else begin
              next_st.fault = 1'b1;
            end
          end else if (FLASH_OPERATION_CONTROL[`FPP_COMMIT_BIT]) begin
            next_st.op[`FPP_COMMIT_BIT] = 1'b1;
            next_st.commit_pe = FLASH_TARGET_ADDRESS[0];
            next_st.state = COMMIT;
            pulse_start = 1'b1;
          end
        end
      end
      PROGRAM: begin
        if (pulse_done) begin
          array_write = 1'b1;
          next_st.op = '0;
          next_st.state = IDLE;
        end
      end
      PAGE_ERASE: begin
        if (pulse_done) begin
          next_st.erase_run = 1'b1;
          next_st.page_idx = '0;
        end
        if (st.erase_run) begin
          array_erase_page = 1'b1;
          next_st.page_idx = st.page_idx + 8'h01;
          if (st.page_idx == 8'hFF) begin
            next_st.erase_run = 1'b0;
            next_st.op = '0;
            next_st.state = IDLE;
          end
        end
      end
      MASS_ERASE: begin
        if (pulse_done) begin
          next_st.erase_run = 1'b1;
          next_st.mass_idx = '0;
        end
        if (st.erase_run) begin
          array_erase_all = 1'b1;
          next_st.mass_idx = st.mass_idx + 11'h001;
          if (&st.mass_idx) begin
            next_st.erase_run = 1'b0;
            next_st.op = '0;
            next_st.state = IDLE;
          end
        end
      end
      COMMIT: begin
        if (pulse_done) begin
          if (st.commit_pe) begin
            next_st.pe_saved = st.pe_saved & st.pe_live;
          end else begin
            next_st.re_saved = st.re_saved & st.re_live;
          end
          next_st.op = '0;
          next_st.state = IDLE;
        end
      end
      default: begin
        next_st.state = IDLE;
        next_st.op = '0;
      end
    endcase

    if (POWER_ON_RESET) begin
      next_st.pe_live = st.pe_saved;
      next_st.re_live = st.re_saved;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st          <= '0;
      st.state    <= IDLE;
      st.pe_live  <= `FPP_PROT_OPEN;
      st.re_live  <= `FPP_PROT_OPEN;
      st.pe_saved <= `FPP_PROT_OPEN;
      st.re_saved <= `FPP_PROT_OPEN;
      st.reload   <= `FPP_USEC_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Array storage; a program only clears bits, as real flash cells do
  always_ff @(posedge MCLK) begin
    if (array_write) begin
      array_mem[word_of(st.addr)] <= array_mem[word_of(st.addr)] & st.data;
    end
    if (array_erase_page) begin
      array_mem[{st.addr[`FPP_ADDR_W-1:`FPP_PAGE_LSB], st.page_idx}] <= `FPP_ERASED_WORD;
    end
    if (array_erase_all) begin
      array_mem[st.mass_idx] <= `FPP_ERASED_WORD;
    end
  end

  assign READ_DATA                 = st.rdata;
  assign READ_VALID                = st.rvalid;
  assign OPERATION_BUSY            = st.op;
  assign BLOCK_PROGRAM_ENABLE_BITS = st.pe_live;
  assign BLOCK_READ_ENABLE_BITS    = st.re_live;
  assign RELOAD_VALUE              = st.reload;
  assign ACCESS_FAULT_RAW          = st.fault;
  assign ACCESS_FAULT_IRQ          = st.fault & ACCESS_FAULT_MASK;
endmodule : flash_program_protect
`default_nettype wire

// *** src/flash_pulse_timer.sv ***
`include "flash_program_protect_defines.svh"
`default_nettype none
// Microsecond tick divider and pulse length counter for high-voltage pulses.
module flash_pulse_timer (
  input  wire logic                    MCLK,
  input  wire logic                    RST_B,
  input  wire logic                    START,
  input  wire logic [`FPP_USEC_W-1:0]  RELOAD,
  input  wire logic [`FPP_US_W-1:0]    LENGTH_US,
  output logic                         DONE
);
  typedef struct packed {
    logic [`FPP_USEC_W-1:0] tick;
    logic [`FPP_US_W-1:0]   us_left;
    logic                   busy;
    logic                   done;
  } timer_state_type;

  timer_state_type st;
  timer_state_type next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (START) begin
      next_st.busy    = 1'b1;
      next_st.tick    = RELOAD;
      next_st.us_left = LENGTH_US;
    end else if (st.busy) begin
      if (st.tick == '0) begin
        next_st.tick = RELOAD;
        if (st.us_left <= 16'h0001) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end else begin
          next_st.us_left = st.us_left - 16'h0001;
        end
      end else begin
        next_st.tick = st.tick - 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign DONE = st.done;
endmodule : flash_pulse_timer
`default_nettype wire

// *** verif/core_bus_model.sv ***
`default_nettype none
module core_bus_model (
  input  wire logic        mclk,
  input  wire logic [3:0]  busy,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic [12:0]      addr,
  output logic [31:0]      wdata,
  output logic [31:0]      ctrl,
  output logic             cwr,
  output logic             rreq,
  output logic             fetch,
  output logic [12:0]      raddr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr, wdata, ctrl, cwr, rreq, fetch, raddr} = '0;
  end
  // no stall mid-operation; callers give aligned addresses, except commit, which uses bit 0
  task automatic op(input logic [12:0] a, input logic [31:0] d, input logic [31:0] c,
                    output bit late);
    int n;
    n = 0;
    @(posedge mclk);
    wdata <= d;
    addr <= a;
    ctrl <= c;
    cwr <= 1'b1;
    @(posedge mclk);
    cwr <= 1'b0;
    @(posedge mclk);
    // Polls the busy bit as software would, but never forever
    while (busy !== 4'h0 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    late = (n == 9000);
  endtask : op
  task automatic rd(input logic [12:0] a, input logic f, output logic [31:0] q,
                    output bit late);
    @(posedge mclk);
    raddr <= a;
    fetch <= f;
    rreq <= 1'b1;
    @(posedge mclk);
    rreq <= 1'b0;
    @(negedge mclk);
    q = rdata;
    late = (rvalid !== 1'b1);
  endtask : rd
endmodule : core_bus_model
`default_nettype wire

// *** verif/flash_program_protect_chk.sv ***
`default_nettype none
module flash_program_protect_chk (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic        POWER_ON_RESET,
  input wire logic [12:0] FLASH_TARGET_ADDRESS,
  input wire logic [31:0] FLASH_OPERATION_CONTROL,
  input wire logic        CONTROL_WRITE,
  input wire logic        ACCESS_FAULT_MASK,
  input wire logic        READ_REQUEST,
  input wire logic        READ_IS_FETCH,
  input wire logic [12:0] READ_ADDRESS,
  input wire logic [31:0] READ_DATA,
  input wire logic        READ_VALID,
  input wire logic [3:0]  OPERATION_BUSY,
  input wire flash_program_protect_pkg::block_bits_type BLOCK_PROGRAM_ENABLE_BITS,
  input wire flash_program_protect_pkg::block_bits_type BLOCK_READ_ENABLE_BITS,
  input wire logic [7:0]  RELOAD_VALUE,
  input wire logic        ACCESS_FAULT_RAW,
  input wire logic        ACCESS_FAULT_IRQ
);
  logic [15:0] busy_cycles;
  logic        go_ok;
  logic [1:0]  blk;
  logic [15:0] us;
  assign blk = FLASH_TARGET_ADDRESS[12:11];
  assign us = {8'h00, RELOAD_VALUE} + 16'h0001;
  assign go_ok = CONTROL_WRITE && OPERATION_BUSY == 4'h0
                 && FLASH_OPERATION_CONTROL[31:16] == 16'hA442;
  // Length of the current operation, checked when the program or page erase busy bit falls
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cycles <= 16'h0000;
    end else if (OPERATION_BUSY == 4'h0) begin
      busy_cycles <= 16'h0000;
    end else begin
      busy_cycles <= busy_cycles + 16'h0001;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_prog_start: assert property (
    go_ok && FLASH_OPERATION_CONTROL[0] && BLOCK_PROGRAM_ENABLE_BITS[blk]
    |=> OPERATION_BUSY == 4'h1) else $error("program not started");
  a_prot_reject: assert property (
    go_ok && FLASH_OPERATION_CONTROL[1:0] != 2'h0 && !BLOCK_PROGRAM_ENABLE_BITS[blk]
    |=> OPERATION_BUSY == 4'h0 && ACCESS_FAULT_RAW) else $error("protected change taken");
  a_mass_reject: assert property (
    go_ok && FLASH_OPERATION_CONTROL[2:0] == 3'h4 && BLOCK_PROGRAM_ENABLE_BITS != 4'hF
    |=> OPERATION_BUSY == 4'h0 && ACCESS_FAULT_RAW) else $error("mass erase not refused");
  a_read_zero: assert property (
    READ_REQUEST && !READ_IS_FETCH && !BLOCK_READ_ENABLE_BITS[READ_ADDRESS[12:11]]
    |=> READ_VALID && READ_DATA == 32'h0 && ACCESS_FAULT_RAW) else $error("read not refused");
  a_fetch_open: assert property (
    READ_REQUEST && READ_IS_FETCH && !ACCESS_FAULT_RAW && !CONTROL_WRITE
    |=> READ_VALID && !ACCESS_FAULT_RAW) else $error("fetch refused");
  a_irq_mask: assert property (
    ACCESS_FAULT_IRQ == (ACCESS_FAULT_RAW && ACCESS_FAULT_MASK)) else $error("irq mask wrong");
  a_bits_only_clear: assert property (
    !POWER_ON_RESET |=> ({BLOCK_PROGRAM_ENABLE_BITS, BLOCK_READ_ENABLE_BITS}
    & ~$past({BLOCK_PROGRAM_ENABLE_BITS, BLOCK_READ_ENABLE_BITS})) == 8'h00)
    else $error("protection bit set");
  a_prog_len: assert property (
    $fell(OPERATION_BUSY[0]) |-> busy_cycles >= us * 16'h0014 - 16'h0001
    && busy_cycles <= us * 16'h0014 + 16'h0003) else $error("program pulse length wrong");
  a_erase_len: assert property (
    $fell(OPERATION_BUSY[1]) |-> busy_cycles >= us * 16'h0028 + 16'h00FF)
    else $error("erase too short");
endmodule : flash_program_protect_chk
bind flash_program_protect flash_program_protect_chk u_chk (.*);
`default_nettype wire

// *** verif/tb.sv ***
`default_nettype none
module tb;
  import flash_program_protect_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, por, rl_wr, pe_wr, re_wr, mask, fclr;
  logic [7:0] reload;
  block_bits_type pdata;
  wire logic [12:0] addr, raddr;
  wire logic [31:0] wdata, ctrl, rdata;
  wire logic cwr, rreq, fetch, rvalid, fraw, firq;
  wire logic [3:0] busy;
  wire block_bits_type ppe, pre;
  wire logic [7:0] rlv;
  int miscompares = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  flash_program_protect u_dut (.MCLK(mclk), .RST_B(rst_b), .POWER_ON_RESET(por),
    .MICROSECOND_TICK_RELOAD(reload), .RELOAD_WRITE(rl_wr), .FLASH_TARGET_ADDRESS(addr),
    .FLASH_WRITE_DATA(wdata), .FLASH_OPERATION_CONTROL(ctrl), .CONTROL_WRITE(cwr),
    .PROTECT_WRITE_DATA(pdata), .PROGRAM_ENABLE_WRITE(pe_wr), .READ_ENABLE_WRITE(re_wr),
    .ACCESS_FAULT_MASK(mask), .FAULT_CLEAR(fclr), .READ_REQUEST(rreq), .READ_IS_FETCH(fetch),
    .READ_ADDRESS(raddr), .READ_DATA(rdata), .READ_VALID(rvalid), .OPERATION_BUSY(busy),
    .BLOCK_PROGRAM_ENABLE_BITS(ppe), .BLOCK_READ_ENABLE_BITS(pre), .RELOAD_VALUE(rlv),
    .ACCESS_FAULT_RAW(fraw), .ACCESS_FAULT_IRQ(firq));
  core_bus_model u_core (.mclk(mclk), .busy(busy), .rdata(rdata), .rvalid(rvalid),
    .addr(addr), .wdata(wdata), .ctrl(ctrl), .cwr(cwr), .rreq(rreq), .fetch(fetch),
    .raddr(raddr));
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic [12:0] a, input logic [31:0] d, input logic [31:0] c);
    bit late;
    u_core.op(a, d, c, late);
    if (late) begin
      miscompares++;
      report_and_stop();
    end
  endtask : go
  task automatic rdc(input logic [12:0] a, input logic f, input logic [31:0] exp);
    logic [31:0] q;
    bit late;
    u_core.rd(a, f, q, late);
    if (late) begin
      miscompares++;
      report_and_stop();
    end
    chk(q, exp);
  endtask : rdc
  // Drives one of the tb-owned strobes for a single cycle
  task automatic strobe(input int which, input logic [3:0] v);
    @(posedge mclk);
    pdata <= v;
    {por, pe_wr, re_wr, fclr} <= 4'h8 >> which;
    @(posedge mclk);
    {por, pe_wr, re_wr, fclr} <= 4'h0;
    @(posedge mclk);
  endtask : strobe
  initial begin
    {mclk, rst_b, por, rl_wr, pe_wr, re_wr, mask, fclr} = '0;
    reload = 8'h00;
    pdata = 4'hF;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk(ppe, 4'hF);
    chk(pre, 4'hF);
    chk(rlv, 8'h13);
    // Software reloads the tick for the 100 MHz clock before any change
    reload <= 8'h63;
    rl_wr <= 1'b1;
    @(posedge mclk);
    rl_wr <= 1'b0;
    @(posedge mclk);
    chk(rlv, 8'h63);
    $display("test reset done");
    go(13'h0000, 32'h0, 32'hA4420004);
    rdc(13'h1FFC, 1'b0, 32'hFFFFFFFF);
    go(13'h0004, 32'h12345678, 32'hA4420001);
    go(13'h0404, 32'hA5A5A5A5, 32'hA4420001);
    rdc(13'h0004, 1'b0, 32'h12345678);
    go(13'h0000, 32'h0, 32'hA4420002);
    rdc(13'h0004, 1'b0, 32'hFFFFFFFF);
    rdc(13'h0404, 1'b0, 32'hA5A5A5A5);
    go(13'h0008, 32'h0, 32'hB4420001);
    rdc(13'h0008, 1'b0, 32'hFFFFFFFF);
    $display("test program erase done");
    strobe(1, 4'hE);
    go(13'h0008, 32'h0, 32'hA4420001);
    chk(fraw, 1'b1);
    chk(firq, 1'b0);
    mask <= 1'b1;
    @(posedge mclk);
    chk(firq, 1'b1);
    rdc(13'h0008, 1'b0, 32'hFFFFFFFF);
    go(13'h0000, 32'h0, 32'hA4420004);
    rdc(13'h0404, 1'b0, 32'hA5A5A5A5);
    strobe(3, 4'hF);
    chk(fraw, 1'b0);
    strobe(2, 4'hE);
    rdc(13'h0404, 1'b1, 32'hA5A5A5A5);
    chk(fraw, 1'b0);
    rdc(13'h0404, 1'b0, 32'h0);
    chk(fraw, 1'b1);
    chk(firq, 1'b1);
    $display("test protection done");
    strobe(0, 4'hF);
    chk({ppe, pre}, 8'hFF);
    strobe(1, 4'h7);
    go(13'h0001, 32'h0, 32'hA4420008);
    strobe(0, 4'hF);
    chk({ppe, pre}, 8'h7F);
    strobe(2, 4'hB);
    go(13'h0000, 32'h0, 32'hA4420008);
    strobe(0, 4'hF);
    chk({ppe, pre}, 8'h7B);
    $display("test commit done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
